// ===== common/nvh_pkg.sv
// Package for the host-side controller of an 8K x 8 static memory with shadow array.
// Assumes a single 250 MHz system clock and pins sampled synchronously.
package nvh_pkg;

    // =========================================================================
    // Widths and sizes
    localparam int ADDR_W = 13;
    localparam int DATA_W = 8;
    localparam int DEPTH  = 8192;

    // =========================================================================
    // Timing in nanoseconds and derived cycle counts at 4 ns
    localparam int CLK_PERIOD_NS         = 4;
    localparam int ADDR_ACCESS_NS        = 35;
    localparam int SELECT_ACCESS_NS      = 35;
    localparam int OUTEN_ACCESS_NS       = 20;
    localparam int DATA_SETUP_NS         = 15;
    localparam int WRITE_PULSE_NS        = 25;
    localparam int RECOVER_NS            = 8;
    localparam int ADDR_ACCESS_CYC   = (ADDR_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SELECT_ACCESS_CYC = (SELECT_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OUTEN_ACCESS_CYC  = (OUTEN_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READ_ACCESS_CYC   = (SELECT_ACCESS_CYC > OUTEN_ACCESS_CYC) ?
                                       SELECT_ACCESS_CYC : OUTEN_ACCESS_CYC;
    localparam int DATA_SETUP_CYC    = (DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRITE_PULSE_RAW   = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRITE_PULSE_CYC   = (WRITE_PULSE_RAW > DATA_SETUP_CYC) ?
                                       WRITE_PULSE_RAW : DATA_SETUP_CYC;
    localparam int RECOVER_CYC       = (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Long waits in microseconds; cycle counts are top-level parameters.
    localparam int SAVE_TIME_US      = 10;
    localparam int RESTORE_TIME_US   = 20;
    localparam int POWERUP_TIME_US   = 500;
    localparam int CYC_PER_US        = 1000 / CLK_PERIOD_NS;
    localparam int SAVE_CYC          = SAVE_TIME_US * CYC_PER_US;
    localparam int RESTORE_CYC       = RESTORE_TIME_US * CYC_PER_US;
    localparam int POWERUP_CYC       = POWERUP_TIME_US * CYC_PER_US;
    localparam int CNT_W             = 20;

    // =========================================================================
    // Six-step shadow command addresses
    localparam logic [12:0] SEQ_A0      = 13'h0000;
    localparam logic [12:0] SEQ_A1      = 13'h1555;
    localparam logic [12:0] SEQ_A2      = 13'h0AAA;
    localparam logic [12:0] SEQ_A3      = 13'h1FFF;
    localparam logic [12:0] SEQ_A4      = 13'h10F0;
    localparam logic [12:0] SEQ_SAVE    = 13'h0F0F;
    localparam logic [12:0] SEQ_RESTORE = 13'h0F0E;
    localparam logic [2:0]  SEQ_STEPS   = 3'h6;

    // =========================================================================
    // Host commands
    typedef enum logic [1:0] {
        NVH_CMD_READ    = 2'h0,
        NVH_CMD_WRITE   = 2'h1,
        NVH_CMD_SAVE    = 2'h2,
        NVH_CMD_RESTORE = 2'h3
    } nvh_cmd_t;

    // Controller states, one-hot.
    typedef enum logic [6:0] {
        NVH_ST_PWRUP = 7'h01,
        NVH_ST_IDLE  = 7'h02,
        NVH_ST_READ  = 7'h04,
        NVH_ST_WRITE = 7'h08,
        NVH_ST_RECOV = 7'h10,
        NVH_ST_SEQ   = 7'h20,
        NVH_ST_BUSY  = 7'h40
    } nvh_state_t;

endpackage

// ===== core/nvh_ctrl.sv
// Host-side controller driving the static memory with shadow array over its pins.
// Assumes pins sampled on i_clk_sys and a testbench resolving the data wire.
`timescale 1ns/1ps

// Contract
// - Host keeps address stable through the whole write cycle.
// - Host drives write data at least data setup time before strobe rises.
// - Host keeps output drive high during every write.
// - Save: six select-controlled reads 0000,1555,0AAA,1FFF,10F0,0F0F.
// - Restore: same five reads then 0F0E as sixth.
// - Sequence steps are read cycles; output drive kept high.
// - Host keeps write strobe high while the power-up restore runs.
// - Write strobe held high during all six sequence reads.
module nvh_ctrl
    import nvh_pkg::*;
#(
    parameter int SAVE_WAIT    = nvh_pkg::SAVE_CYC,
    parameter int RESTORE_WAIT = nvh_pkg::RESTORE_CYC,
    parameter int POWERUP_WAIT = nvh_pkg::POWERUP_CYC
)(
    input  wire logic                      i_clk_sys,
    input  wire logic                      i_rst,
    input  wire logic                      i_ce,
    input  wire logic                      i_req_valid,
    input  wire nvh_pkg::nvh_cmd_t         i_req_cmd,
    input  wire logic [nvh_pkg::ADDR_W-1:0] i_req_addr,
    input  wire logic [nvh_pkg::DATA_W-1:0] i_req_wdata,
    input  wire logic                      i_supply_low,
    output logic                           o_req_ready,
    output logic                           o_rsp_valid,
    output logic                           o_rsp_refused,
    output logic [nvh_pkg::DATA_W-1:0]     o_rsp_rdata,
    output logic [nvh_pkg::ADDR_W-1:0]     o_address_lines,
    output logic [nvh_pkg::DATA_W-1:0]     o_data_io,
    output logic                           o_data_io_oe,
    input  wire logic [nvh_pkg::DATA_W-1:0] i_data_io,
    output logic                           o_chip_select_n,
    output logic                           o_output_drive_en_n,
    output logic                           o_write_strobe_n
);
    import nvh_pkg::*;

    // =========================================================================
    // State and counters
    nvh_state_t         state_q;
    logic [CNT_W-1:0]   cnt_q;
    logic [2:0]         step_q;
    logic               is_save_q;
    logic               seq_read;

    assign seq_read = (step_q != 3'h0);

    function automatic logic [12:0] seq_addr(input logic [2:0] s, input logic sv);
        logic [12:0] a;
        a = SEQ_A0;
        unique case (s)
            3'h0: a = SEQ_A0;
            3'h1: a = SEQ_A1;
            3'h2: a = SEQ_A2;
            3'h3: a = SEQ_A3;
            3'h4: a = SEQ_A4;
            default: a = sv ? SEQ_SAVE : SEQ_RESTORE;
        endcase
        return a;
    endfunction

    // =========================================================================
    // Main sequencer
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            state_q             <= NVH_ST_PWRUP;
            cnt_q               <= '0;
            step_q              <= 3'h0;
            is_save_q           <= 1'b0;
            o_req_ready         <= 1'b0;
            o_rsp_valid         <= 1'b0;
            o_rsp_refused       <= 1'b0;
            o_rsp_rdata         <= 8'h00;
            o_address_lines     <= 13'h0000;
            o_data_io           <= 8'h00;
            o_data_io_oe        <= 1'b0;
            o_chip_select_n     <= 1'b1;
            o_output_drive_en_n <= 1'b1;
            o_write_strobe_n    <= 1'b1;
        end
        else if (i_ce)
        begin
            o_rsp_valid   <= 1'b0;
            o_rsp_refused <= 1'b0;
            unique case (state_q)
                NVH_ST_PWRUP:
                begin
                    // Strobe held high while the device restores itself.
                    o_write_strobe_n <= 1'b1;
                    if (cnt_q == CNT_W'(POWERUP_WAIT - 1))
                    begin
                        cnt_q       <= '0;
                        state_q     <= NVH_ST_IDLE;
                        o_req_ready <= 1'b1;
                    end
                    else
                        cnt_q <= cnt_q + 1'b1;
                end
                NVH_ST_IDLE:
                begin
                    if (i_req_valid)
                    begin
                        o_req_ready <= 1'b0;
                        cnt_q       <= '0;
                        unique case (i_req_cmd)
                            NVH_CMD_READ:
                            begin
                                o_address_lines     <= i_req_addr;
                                o_chip_select_n     <= 1'b0;
                                o_output_drive_en_n <= 1'b0;
                                state_q             <= NVH_ST_READ;
                            end
                            NVH_CMD_WRITE:
                            begin
                                if (i_supply_low)
                                begin
                                    o_rsp_valid   <= 1'b1;
                                    o_rsp_refused <= 1'b1;
                                    o_req_ready   <= 1'b1;
                                end
                                else
                                begin
                                    o_address_lines <= i_req_addr;
                                    o_data_io       <= i_req_wdata;
                                    o_data_io_oe    <= 1'b1;
                                    o_chip_select_n <= 1'b0;
                                    o_write_strobe_n <= 1'b0;
                                    o_output_drive_en_n <= 1'b1;
                                    state_q         <= NVH_ST_WRITE;
                                end
                            end
                            NVH_CMD_SAVE, NVH_CMD_RESTORE:
                            begin
                                if (i_supply_low && i_req_cmd == NVH_CMD_SAVE)
                                begin
                                    o_rsp_valid   <= 1'b1;
                                    o_rsp_refused <= 1'b1;
                                    o_req_ready   <= 1'b1;
                                end
                                else
                                begin
                                    is_save_q       <= (i_req_cmd == NVH_CMD_SAVE);
                                    step_q          <= 3'h0;
                                    o_address_lines <= SEQ_A0;
                                    o_chip_select_n <= 1'b0;
                                    state_q         <= NVH_ST_SEQ;
                                end
                            end
                        endcase
                    end
                end
                NVH_ST_READ:
                begin
                    // Controls and address held until capture.
                    if (cnt_q == CNT_W'(READ_ACCESS_CYC))
                    begin
                        o_rsp_rdata         <= i_data_io;
                        o_rsp_valid         <= 1'b1;
                        o_chip_select_n     <= 1'b1;
                        o_output_drive_en_n <= 1'b1;
                        cnt_q               <= '0;
                        state_q             <= NVH_ST_RECOV;
                    end
                    else
                        cnt_q <= cnt_q + 1'b1;
                end
                NVH_ST_WRITE:
                begin
                    if (cnt_q == CNT_W'(WRITE_PULSE_CYC - 1))
                    begin
                        o_write_strobe_n <= 1'b1;
                        o_chip_select_n  <= 1'b1;
                        o_rsp_valid      <= 1'b1;
                        cnt_q            <= '0;
                        state_q          <= NVH_ST_RECOV;
                    end
                    else
                        cnt_q <= cnt_q + 1'b1;
                end
                NVH_ST_RECOV:
                begin
                    o_data_io_oe <= 1'b0;
                    if (cnt_q == CNT_W'(RECOVER_CYC - 1))
                    begin
                        cnt_q <= '0;
                        if (seq_read)
                        begin
                            o_address_lines <= seq_addr(step_q, is_save_q);
                            o_chip_select_n <= 1'b0;
                            state_q         <= NVH_ST_SEQ;
                        end
                        else
                        begin
                            o_req_ready <= 1'b1;
                            state_q     <= NVH_ST_IDLE;
                        end
                    end
                    else
                        cnt_q <= cnt_q + 1'b1;
                end
                NVH_ST_SEQ:
                begin
                    if (cnt_q == CNT_W'(SELECT_ACCESS_CYC))
                    begin
                        o_chip_select_n <= 1'b1;
                        cnt_q           <= '0;
                        if (step_q == SEQ_STEPS - 3'h1)
                        begin
                            step_q  <= 3'h0;
                            state_q <= NVH_ST_BUSY;
                        end
                        else
                        begin
                            step_q  <= step_q + 3'h1;
                            state_q <= NVH_ST_RECOV;
                        end
                    end
                    else
                        cnt_q <= cnt_q + 1'b1;
                end
                NVH_ST_BUSY:
                begin
                    // Device works alone; no pins move.
                    if (cnt_q == CNT_W'((is_save_q ? SAVE_WAIT : RESTORE_WAIT) - 1))
                    begin
                        cnt_q       <= '0;
                        o_rsp_valid <= 1'b1;
                        o_req_ready <= 1'b1;
                        state_q     <= NVH_ST_IDLE;
                    end
                    else
                        cnt_q <= cnt_q + 1'b1;
                end
                default:
                    state_q <= NVH_ST_IDLE;
            endcase
        end
    end

    // =========================================================================
    // Checks
    chk_write_no_outen: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        !o_write_strobe_n |-> o_output_drive_en_n)
        else $error("output drive low during write");

    chk_seq_strobe_high: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (state_q == NVH_ST_SEQ) |-> o_write_strobe_n && o_output_drive_en_n)
        else $error("sequence read not a plain select read");

    chk_write_addr_stable: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (!o_write_strobe_n && $past(!o_write_strobe_n)) |-> $stable(o_address_lines))
        else $error("address moved during write");

    chk_write_data_oe: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        !o_write_strobe_n |-> o_data_io_oe)
        else $error("write data not driven");

    // Write opens with data driven, then strobe, select and data hold for the pulse.
    sequence seq_write_open;
        $fell(o_write_strobe_n) ##0 o_data_io_oe;
    endsequence

    sequence seq_write_held;
        (!o_write_strobe_n && o_data_io_oe && !o_chip_select_n) [*6];
    endsequence

    chk_write_pulse_len: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        seq_write_open |=> seq_write_held)
        else $error("write strobe pulse too short");

    chk_pwrup_strobe: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (state_q == NVH_ST_PWRUP) |-> o_write_strobe_n && o_chip_select_n)
        else $error("device selected during power-up");

    chk_refuse_low: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_ce && state_q == NVH_ST_IDLE && i_req_valid && i_supply_low
         && i_req_cmd == NVH_CMD_WRITE) |=> o_rsp_refused && o_write_strobe_n)
        else $error("write not refused at low supply");

    chk_busy_idle_pins: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (state_q == NVH_ST_BUSY) |-> o_chip_select_n && !o_req_ready)
        else $error("access during shadow operation");

    chk_read_outen: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (state_q == NVH_ST_READ) |-> !o_chip_select_n && !o_output_drive_en_n
        && o_write_strobe_n && !o_data_io_oe)
        else $error("bad read pin levels");

endmodule // nvh_ctrl

// ===== testbench/nv_shadow_sram_bench.sv
// Self-checking bench for the host controller against the behavioural memory model.
// Assumes the controller parameters shortened for simulation and a 250 MHz clock.
`timescale 1ns/1ps
module nv_shadow_sram_bench;
    import nvh_pkg::*;
    localparam int SW = 20;
    localparam int RW = 30;
    localparam int PW = 10;
    logic clk = 1'b0, rst = 1'b1, ce = 1'b1, req_valid = 1'b0, supply_low = 1'b0;
    nvh_cmd_t    req_cmd = NVH_CMD_READ;
    logic [12:0] req_addr = 13'h0000;
    logic [7:0]  req_wdata = 8'h00;
    logic req_ready, rsp_valid, rsp_refused, host_oe, cs_n, oe_n, we_n;
    logic [12:0] addr_pins;
    logic [7:0]  rsp_rdata, host_data, wire_data, rd;
    logic        refd;
    int miscompares = 0, checked = 0, cycles = 0, saves, restores, viol;

    nvh_ctrl #(.SAVE_WAIT(SW), .RESTORE_WAIT(RW), .POWERUP_WAIT(PW)) dut (
        .i_clk_sys(clk), .i_rst(rst), .i_ce(ce), .i_req_valid(req_valid),
        .i_req_cmd(req_cmd), .i_req_addr(req_addr), .i_req_wdata(req_wdata),
        .i_supply_low(supply_low), .o_req_ready(req_ready), .o_rsp_valid(rsp_valid),
        .o_rsp_refused(rsp_refused), .o_rsp_rdata(rsp_rdata), .o_address_lines(addr_pins),
        .o_data_io(host_data), .o_data_io_oe(host_oe), .i_data_io(wire_data),
        .o_chip_select_n(cs_n), .o_output_drive_en_n(oe_n), .o_write_strobe_n(we_n));

    nvh_mem_model #(.SAVE_BUSY(SW - 2), .RESTORE_BUSY(RW - 2), .PWR_BUSY(PW - 2)) mem (
        .i_clk_sys(clk), .i_rst(rst), .i_supply_low(supply_low), .i_address_lines(addr_pins),
        .i_host_data(host_data), .i_host_oe(host_oe), .i_chip_select_n(cs_n),
        .i_output_drive_en_n(oe_n), .i_write_strobe_n(we_n), .o_wire(wire_data),
        .o_saves(saves), .o_restores(restores), .o_viol(viol));

    initial
    begin
        forever #2 clk = ~clk;
    end

    // =========================================================================
    // Shared comparison, request and closing tasks.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
        end
    endtask

    task automatic do_req(input nvh_cmd_t cmd, input logic [12:0] a, input logic [7:0] d,
                          input bit freeze);
        int n;
        n = 0;
        @(negedge clk);
        req_valid = 1'b1;
        req_cmd = cmd;
        req_addr = a;
        req_wdata = d;
        while (req_ready !== 1'b1 && n < 5000)
        begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        req_valid = 1'b0;
        if (freeze)
        begin
            ce = 1'b0;
            repeat (4) @(negedge clk);
            ce = 1'b1;
        end
        while (rsp_valid !== 1'b1 && n < 5000)
        begin
            @(negedge clk);
            n++;
        end
        check(n < 5000, 1, "response wait");
        refd = rsp_refused;
        rd = rsp_rdata;
    endtask

    task automatic close_out();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // =========================================================================
    // Scenarios.
    task automatic t_powerup();
        repeat (PW - 1) @(negedge clk);
        check(req_ready, 1'b0, "ready during power-up restore");
        do_req(NVH_CMD_READ, 13'h0123, 8'h00, 1'b0);
        check(rd, 8'h23 ^ 8'hA5, "restored byte after power-up");
        $display("test powerup done");
    endtask

    task automatic t_write_read();
        logic [12:0] al [4] = '{13'h0000, 13'h1FFF, 13'h0AAA, 13'h1234};
        logic [7:0]  dl [4] = '{8'h3C, 8'hC3, 8'hFF, 8'h00};
        for (int i = 0; i < 4; i++)
        begin
            do_req(NVH_CMD_WRITE, al[i], dl[i], 1'b0);
            check(refd, 1'b0, "write accepted");
        end
        for (int i = 0; i < 4; i++)
        begin
            do_req(NVH_CMD_READ, al[i], 8'h00, i == 1);
            check(rd, dl[i], "read back");
        end
        $display("test write_read done");
    endtask

    task automatic t_low_supply();
        supply_low = 1'b1;
        do_req(NVH_CMD_WRITE, 13'h0040, 8'h5A, 1'b0);
        check(refd, 1'b1, "write refused at low supply");
        do_req(NVH_CMD_SAVE, 13'h0000, 8'h00, 1'b0);
        check(refd, 1'b1, "save refused at low supply");
        check(saves, 0, "no save at low supply");
        do_req(NVH_CMD_RESTORE, 13'h0000, 8'h00, 1'b0);
        check(refd, 1'b0, "restore allowed at low supply");
        check(restores, 1, "restore count");
        supply_low = 1'b0;
        do_req(NVH_CMD_READ, 13'h0040, 8'h00, 1'b0);
        check(rd, 8'h40 ^ 8'hA5, "byte unchanged by refused write");
        $display("test low_supply done");
    endtask

    task automatic t_save_restore();
        do_req(NVH_CMD_WRITE, 13'h0200, 8'h11, 1'b0);
        do_req(NVH_CMD_SAVE, 13'h0000, 8'h00, 1'b0);
        check(saves, 1, "save started");
        do_req(NVH_CMD_WRITE, 13'h0200, 8'h22, 1'b0);
        do_req(NVH_CMD_READ, 13'h0200, 8'h00, 1'b0);
        check(rd, 8'h22, "write after save");
        for (int i = 0; i < 2; i++)
        begin
            do_req(NVH_CMD_RESTORE, 13'h0000, 8'h00, 1'b0);
            do_req(NVH_CMD_READ, 13'h0200, 8'h00, 1'b0);
            check(rd, 8'h11, "saved byte restored");
        end
        do_req(NVH_CMD_READ, 13'h1FFF, 8'h00, 1'b0);
        check(rd, 8'hFF ^ 8'hA5, "other saved byte");
        check(restores, 3, "repeated restores");
        $display("test save_restore done");
    endtask

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            miscompares++;
            close_out();
        end
    end

    initial
    begin
        repeat (3) @(negedge clk);
        rst = 1'b0;
        t_powerup();
        t_write_read();
        t_low_supply();
        t_save_restore();
        check(viol, 0, "pin protocol kept");
        close_out();
    end
endmodule // nv_shadow_sram_bench

// ===== testbench/nvh_mem_model.sv
// Behavioural model of the 8K x 8 static memory with shadow array, seen from its pins.
// Assumes pins sampled on the host clock and the host driving the wire when i_host_oe is high.
`timescale 1ns/1ps
module nvh_mem_model
    import nvh_pkg::*;
#(
    parameter int ACC_CYC      = 8,
    parameter int SAVE_BUSY    = 18,
    parameter int RESTORE_BUSY = 28,
    parameter int PWR_BUSY     = 8
)(
    input  wire logic                       i_clk_sys,
    input  wire logic                       i_rst,
    input  wire logic                       i_supply_low,
    input  wire logic [nvh_pkg::ADDR_W-1:0] i_address_lines,
    input  wire logic [nvh_pkg::DATA_W-1:0] i_host_data,
    input  wire logic                       i_host_oe,
    input  wire logic                       i_chip_select_n,
    input  wire logic                       i_output_drive_en_n,
    input  wire logic                       i_write_strobe_n,
    output logic      [nvh_pkg::DATA_W-1:0] o_wire,
    output int                              o_saves,
    output int                              o_restores,
    output int                              o_viol
);
    logic [DATA_W-1:0] mem_q [DEPTH];
    logic [DATA_W-1:0] shadow_q [DEPTH];
    logic [DATA_W-1:0] last_q;
    logic [DATA_W-1:0] data_d1;
    logic [ADDR_W-1:0] adr_d1;
    logic [ADDR_W-1:0] want;
    logic              cs_d1;
    logic              we_d1;
    logic              drv;
    int                busy_q;
    int                acc_q;
    int                step_q;

    // =========================================================================
    // Read path: drives only when selected, output drive on, strobe high, not busy.
    assign drv = !i_chip_select_n && !i_output_drive_en_n && i_write_strobe_n && busy_q == 0;
    assign o_wire = i_host_oe ? i_host_data :
                    (drv && acc_q >= ACC_CYC) ? mem_q[i_address_lines] : ~last_q;
    assign want = (step_q == 0) ? SEQ_A0 : (step_q == 1) ? SEQ_A1 :
                  (step_q == 2) ? SEQ_A2 : (step_q == 3) ? SEQ_A3 : SEQ_A4;

    initial
    begin
        for (int k = 0; k < DEPTH; k++)
            shadow_q[k] = k[7:0] ^ 8'hA5;
    end

    // =========================================================================
    // Pin sampling, sequence detector, shadow operations and host rule checks.
    always @(posedge i_clk_sys)
    begin
        last_q  <= o_wire;
        cs_d1   <= i_chip_select_n;
        we_d1   <= i_write_strobe_n;
        adr_d1  <= i_address_lines;
        data_d1 <= i_host_data;
        acc_q   <= (!drv || i_address_lines != adr_d1) ? 0 : acc_q + 1;
        if (i_host_oe && drv)
            o_viol <= o_viol + 1;
        if (i_rst)
        begin
            for (int k = 0; k < DEPTH; k++)
                mem_q[k] <= shadow_q[k];
            busy_q <= PWR_BUSY;
            step_q <= 0;
            o_saves <= 0;
            o_restores <= 0;
            o_viol <= 0;
        end
        else if (busy_q != 0)
        begin
            busy_q <= busy_q - 1;
            if (!i_chip_select_n || (busy_q == 1 && !i_write_strobe_n))
                o_viol <= o_viol + 1;
        end
        else if (!cs_d1 && !we_d1 && (i_chip_select_n || i_write_strobe_n))
        begin
            if (!i_supply_low)
                mem_q[adr_d1] <= data_d1;
            step_q <= 0;
        end
        else if (!cs_d1 && !we_d1 && i_address_lines != adr_d1)
            o_viol <= o_viol + 1;
        else if (!cs_d1 && we_d1 && i_chip_select_n)
        begin
            if (step_q == 5 && adr_d1 == SEQ_SAVE && !i_supply_low)
            begin
                for (int k = 0; k < DEPTH; k++)
                    shadow_q[k] <= mem_q[k];
                o_saves <= o_saves + 1;
                busy_q <= SAVE_BUSY;
                step_q <= 0;
            end
            else if (step_q == 5 && adr_d1 == SEQ_RESTORE)
            begin
                for (int k = 0; k < DEPTH; k++)
                    mem_q[k] <= shadow_q[k];
                o_restores <= o_restores + 1;
                busy_q <= RESTORE_BUSY;
                step_q <= 0;
            end
            else if (step_q < 5 && adr_d1 == want)
                step_q <= step_q + 1;
            else
                step_q <= (adr_d1 == SEQ_A0) ? 1 : 0;
        end
    end
endmodule // nvh_mem_model
